//--- design/led7_als_pkg.sv
// Constants and types shared by the LED7 level-current and light-comparator control block.
package led7_als_pkg;
  // Register offsets on the serial programming register port.
  localparam logic [7:0] ADDR_LED7_L4       = 8'h28;
  localparam logic [7:0] ADDR_LED7_L5       = 8'h29;
  localparam logic [7:0] ADDR_LIGHT_CTRL    = 8'h2d;
  localparam logic [7:0] ADDR_CMP_LAST      = 8'h39;
  localparam logic [7:0] ADDR_RAW_MAIN      = 8'h40;
  localparam logic [7:0] ADDR_RAW_SECOND    = 8'h41;
  localparam logic [7:0] ADDR_SMOOTH_MAIN   = 8'h42;
  localparam logic [7:0] ADDR_SMOOTH_SECOND = 8'h43;

  // Field layout of the level-current and comparator control registers.
  localparam int CODE_MSB      = 6;
  localparam int CODE_W        = 7;
  localparam int F2_HI         = 7;
  localparam int F2_LO         = 5;
  localparam int FR2_BIT       = 4;
  localparam int F1_HI         = 3;
  localparam int F1_LO         = 1;
  localparam int FR1_BIT       = 0;
  localparam int FILTER_CODE_W = 3;
  localparam int CMP_W         = 4;

  // Reset values.
  localparam logic [6:0] CODE_RESET   = 7'h00;
  localparam logic [2:0] FILTER_RESET = 3'h0;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;

  // Timing: the filter base time doubles with each code step.
  localparam int FILTER_BASE_MS     = 80;
  localparam int CLK_KHZ            = 100000;
  localparam int FILTER_BASE_CYCLES = FILTER_BASE_MS * CLK_KHZ;
  localparam int FILTER_CNT_W       = 30;
  localparam int CONV_CYCLES        = 16;
  localparam int CONV_CNT_W         = 8;

  // Ambient-light level chosen from the main comparator outputs.
  typedef enum logic [2:0] {LEVEL_1, LEVEL_2, LEVEL_3, LEVEL_4, LEVEL_5} level_t;
endpackage

//--- design/led7_als_regs.sv
// LED7 level 4/5 current codes and light-comparator control register slice.
// How it works
// R1: Offset 0x28 holds the level-4 LED7 current code in bits 6:0; bit 7 reads zero.
// R2: Offset 0x29 holds the level-5 LED7 current code in bits 6:0; bit 7 reads zero.
// R3: Range bit 0: code maps on the 30 mA full-scale range.
// R4: Range bit 1: code maps on the doubled 60 mA full-scale range.
// R5: Comparator controls sit at 0x2D to 0x39; raw results read at 0x40 to 0x41, smoothed results at 0x42 to 0x43. This slice holds only 0x2D.
// R6: Offset 0x2D: second filter 7:5, second force 4, main filter 3:1, main force 0.
// R7: Filter code selects 80 ms doubling per step up to 10,240 ms, both sensors.
// R8: Force bit starts conversion while backlight off, clears when done, ignored when on.
// R9: LED7 takes the code of the active level, on the selected range; this slice drives code zero at levels 1 to 3.
`timescale 1ns/1ns
module led7_als_regs
  import led7_als_pkg::*;
#(
  parameter int FILTER_CYCLES = FILTER_BASE_CYCLES,
  parameter int CONV_LEN      = CONV_CYCLES
)
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rd_data,
  input  wire logic             backlight_on,
  input  wire logic             led7_range_select,
  input  wire logic [CMP_W-1:0] cmp_main_in,
  input  wire logic [CMP_W-1:0] cmp_second_in,
  output logic      [CODE_W-1:0] led7_drive_code,
  output logic                  led7_double_range,
  output level_t                als_level
);
  typedef struct packed {
    logic [CODE_W-1:0] l4_code;
    logic [CODE_W-1:0] l5_code;
    logic [2:0]        f2;
    logic              fr2;
    logic [2:0]        f1;
    logic              fr1;
    logic [CMP_W-1:0]  main_sync1;
    logic [CMP_W-1:0]  main_sync2;
    logic [CMP_W-1:0]  second_sync1;
    logic [CMP_W-1:0]  second_sync2;
    logic [CMP_W-1:0]  main_smooth;
    logic [CMP_W-1:0]  second_smooth;
    logic [7:0]        rd_data;
    logic [CODE_W-1:0] drive_code;
    logic              double_range;
    level_t            level;
  } regs_state_t;

  regs_state_t s;
  regs_state_t next_s;
  logic wr_l4;
  logic wr_l5;
  logic wr_ctl;
  logic start_main;
  logic start_second;

  light_sensor_if main_if ();
  light_sensor_if second_if ();

  light_sensor_channel #(.BASE_CYCLES(FILTER_CYCLES), .CONV_LEN(CONV_LEN)) u_main
  (
    .clk   (clk),
    .rst_b (rst_b),
    .bus   (main_if)
  );
  light_sensor_channel #(.BASE_CYCLES(FILTER_CYCLES), .CONV_LEN(CONV_LEN)) u_second
  (
    .clk   (clk),
    .rst_b (rst_b),
    .bus   (second_if)
  );

  // Address decode; other offsets in the comparator range are not held here.
  assign wr_l4  = reg_wr && (reg_addr == ADDR_LED7_L4);
  assign wr_l5  = reg_wr && (reg_addr == ADDR_LED7_L5);
  assign wr_ctl = reg_wr && (reg_addr == ADDR_LIGHT_CTRL); // [R5]

  // A force request only starts a conversion with the backlight off and none pending.
  assign start_main   = wr_ctl && reg_wdata[FR1_BIT] && !backlight_on && !s.fr1; // [R8]
  assign start_second = wr_ctl && reg_wdata[FR2_BIT] && !backlight_on && !s.fr2; // [R8]

  assign main_if.filter_code   = s.f1;
  assign main_if.start         = start_main;
  assign second_if.filter_code = s.f2;
  assign second_if.start       = start_second;

  // Next-state for registers, synchronisers, filtered results and LED7 drive.
  always_comb
  begin
    next_s = s;
    if (wr_l4)
      next_s.l4_code = reg_wdata[CODE_MSB:0]; // [R1]
    if (wr_l5)
      next_s.l5_code = reg_wdata[CODE_MSB:0]; // [R2]
    if (wr_ctl)
    begin
      next_s.f2 = reg_wdata[F2_HI:F2_LO]; // [R6]
      next_s.f1 = reg_wdata[F1_HI:F1_LO]; // [R6]
    end
    // Set beats the completion clear; a force request while the backlight is on is dropped.
    next_s.fr1 = start_main || (s.fr1 && !main_if.done); // [R8]
    next_s.fr2 = start_second || (s.fr2 && !second_if.done); // [R8]

    // Comparator pins are asynchronous, so two flops before any use.
    next_s.main_sync1   = cmp_main_in;
    next_s.main_sync2   = s.main_sync1;
    next_s.second_sync1 = cmp_second_in;
    next_s.second_sync2 = s.second_sync1;
    if (main_if.tick || main_if.done)
      next_s.main_smooth = s.main_sync2; // [R7]
    if (second_if.tick || second_if.done)
      next_s.second_smooth = s.second_sync2; // [R7]

    // Highest tripped comparator picks the level.
    if (s.main_smooth[3])
      next_s.level = LEVEL_5;
    else if (s.main_smooth[2])
      next_s.level = LEVEL_4;
    else if (s.main_smooth[1])
      next_s.level = LEVEL_3;
    else if (s.main_smooth[0])
      next_s.level = LEVEL_2;
    else
      next_s.level = LEVEL_1;

    // Levels 1 to 3 live elsewhere; this slice drives zero current for them.
    unique case (s.level)
      LEVEL_4: next_s.drive_code = s.l4_code; // [R9]
      LEVEL_5: next_s.drive_code = s.l5_code; // [R9]
      default: next_s.drive_code = CODE_RESET;
    endcase
    next_s.double_range = led7_range_select; // [R3] [R4]

    // Read mux, one cycle of latency; unmapped and reserved bits read zero.
    unique case (reg_addr)
      ADDR_LED7_L4:       next_s.rd_data = {1'b0, s.l4_code}; // [R1]
      ADDR_LED7_L5:       next_s.rd_data = {1'b0, s.l5_code}; // [R2]
      ADDR_LIGHT_CTRL:    next_s.rd_data = {s.f2, s.fr2, s.f1, s.fr1}; // [R6]
      ADDR_RAW_MAIN:      next_s.rd_data = {4'h0, s.main_sync2}; // [R5]
      ADDR_RAW_SECOND:    next_s.rd_data = {4'h0, s.second_sync2}; // [R5]
      ADDR_SMOOTH_MAIN:   next_s.rd_data = {4'h0, s.main_smooth}; // [R5]
      ADDR_SMOOTH_SECOND: next_s.rd_data = {4'h0, s.second_smooth}; // [R5]
      default:            next_s.rd_data = BYTE_ZERO;
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign reg_rd_data       = s.rd_data;
  assign led7_drive_code   = s.drive_code;
  assign led7_double_range = s.double_range;
  assign als_level         = s.level;

  // A write to the level-4 register followed at once by a read of it.
  sequence s_l4_write_then_read;
    wr_l4 ##1 (reg_addr == ADDR_LED7_L4);
  endsequence

  property p_l4_store;
    @(posedge clk) disable iff (!rst_b)
      s_l4_write_then_read |=> reg_rd_data == {1'b0, $past(reg_wdata[CODE_MSB:0], 2)};
  endproperty
  a_l4_store: assert property (p_l4_store) else $error("level 4 code not stored"); // [R1]

  property p_l5_store;
    @(posedge clk) disable iff (!rst_b) wr_l5 |=> s.l5_code == $past(reg_wdata[CODE_MSB:0]);
  endproperty
  a_l5_store: assert property (p_l5_store) else $error("level 5 code not stored"); // [R2]

  property p_range_low;
    @(posedge clk) disable iff (!rst_b) !led7_range_select |=> !led7_double_range;
  endproperty
  a_range_low: assert property (p_range_low) else $error("range should be 30 mA"); // [R3]

  property p_range_high;
    @(posedge clk) disable iff (!rst_b) led7_range_select |=> led7_double_range;
  endproperty
  a_range_high: assert property (p_range_high) else $error("range should be 60 mA"); // [R4]

  property p_raw_read;
    @(posedge clk) disable iff (!rst_b)
      reg_addr == ADDR_RAW_MAIN |=> reg_rd_data == {4'h0, $past(s.main_sync2)};
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw main read wrong"); // [R5]

  property p_ctl_fields;
    @(posedge clk) disable iff (!rst_b)
      wr_ctl |=> (s.f2 == $past(reg_wdata[F2_HI:F2_LO]))
                 && (s.f1 == $past(reg_wdata[F1_HI:F1_LO]));
  endproperty
  a_ctl_fields: assert property (p_ctl_fields) else $error("control fields misplaced"); // [R6]

  property p_force_ignored;
    @(posedge clk) disable iff (!rst_b) (wr_ctl && backlight_on && !s.fr1) |=> !s.fr1;
  endproperty
  a_force_ignored: assert property (p_force_ignored) else $error("force taken while lit"); // [R8]

  property p_force_cleared;
    @(posedge clk) disable iff (!rst_b) (s.fr1 && main_if.done && !start_main) |=> !s.fr1;
  endproperty
  a_force_cleared: assert property (p_force_cleared) else $error("force not cleared"); // [R8]

  property p_level_drive;
    @(posedge clk) disable iff (!rst_b)
      (s.level == LEVEL_5) |=> led7_drive_code == $past(s.l5_code);
  endproperty
  a_level_drive: assert property (p_level_drive) else $error("LED7 code not from level"); // [R9]

  property p_level4_drive;
    @(posedge clk) disable iff (!rst_b)
      (s.level == LEVEL_4) |=> led7_drive_code == $past(s.l4_code);
  endproperty
  a_level4_drive: assert property (p_level4_drive) else $error("LED7 code not level 4"); // [R9]

  // A pending force bit means its channel is converting or has just finished.
  property p_fr1_busy;
    @(posedge clk) disable iff (!rst_b) s.fr1 |-> (main_if.busy || main_if.done);
  endproperty
  a_fr1_busy: assert property (p_fr1_busy) else $error("main force idle"); // [R8]

  property p_fr2_busy;
    @(posedge clk) disable iff (!rst_b) s.fr2 |-> (second_if.busy || second_if.done);
  endproperty
  a_fr2_busy: assert property (p_fr2_busy) else $error("second force idle"); // [R8]
endmodule

//--- design/light_sensor_channel.sv
// One light-sensor channel: filter period timer and forced conversion timer.
`timescale 1ns/1ns
module light_sensor_channel
  import led7_als_pkg::*;
#(
  parameter int BASE_CYCLES = FILTER_BASE_CYCLES,
  parameter int CONV_LEN    = CONV_CYCLES
)
(
  input wire logic       clk,
  input wire logic       rst_b,
  light_sensor_if.chan   bus
);
  typedef struct packed {
    logic [FILTER_CNT_W-1:0] period_cnt;
    logic [CONV_CNT_W-1:0]   conv_cnt;
    logic                    busy;
    logic                    done;
    logic                    tick;
  } chan_state_t;

  // Done is raised by the edge that ends the count, so it is seen one edge later.
  localparam int CONV_WAIT = CONV_LEN + 1;

  chan_state_t s;
  chan_state_t next_s;
  logic [FILTER_CNT_W-1:0] limit;

  // Period is the base time shifted by the code, so each step doubles it.
  assign limit = FILTER_CNT_W'(BASE_CYCLES) << bus.filter_code; // [R7]

  // Next-state: the filter timer free-runs; a start arms a fixed conversion.
  always_comb
  begin
    next_s      = s;
    next_s.tick = 1'b0;
    next_s.done = 1'b0;
    if (s.period_cnt >= limit - FILTER_CNT_W'(1))
    begin
      // Using >= keeps the timer sane when the code shrinks mid-period.
      next_s.period_cnt = '0;
      next_s.tick       = 1'b1; // [R7]
    end
    else
    begin
      next_s.period_cnt = s.period_cnt + FILTER_CNT_W'(1);
    end
    if (s.busy)
    begin
      if (s.conv_cnt == CONV_CNT_W'(CONV_LEN - 1))
      begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1; // [R8]
      end
      else
      begin
        next_s.conv_cnt = s.conv_cnt + CONV_CNT_W'(1);
      end
    end
    else if (bus.start)
    begin
      next_s.busy     = 1'b1; // [R8]
      next_s.conv_cnt = '0;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign bus.busy = s.busy;
  assign bus.done = s.done;
  assign bus.tick = s.tick;

  sequence s_start;
    bus.start && !s.busy;
  endsequence
  sequence s_finish;
    ##CONV_WAIT s.done;
  endsequence

  property p_conv_len;
    @(posedge clk) disable iff (!rst_b) s_start |-> s_finish;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // [R8]

  // An early wrap after the code shrank mid-period is a legal short period, so it is left out.
  property p_filter_period;
    @(posedge clk) disable iff (!rst_b)
      (s.tick && ($past(s.period_cnt) < $past(limit))) |->
        ($past(s.period_cnt) + FILTER_CNT_W'(1)
         == FILTER_CNT_W'(BASE_CYCLES * (1 << $past(bus.filter_code))));
  endproperty
  a_filter_period: assert property (p_filter_period) else $error("filter period wrong"); // [R7]
endmodule

//--- design/light_sensor_if.sv
// Carrier between the register block and one light-sensor channel.
`timescale 1ns/1ns
interface light_sensor_if;
  logic [2:0] filter_code;
  logic       start;
  logic       busy;
  logic       done;
  logic       tick;

  modport ctrl (output filter_code, output start, input busy, input done, input tick);
  modport chan (input filter_code, input start, output busy, output done, output tick);
endinterface

//--- verif/tb.sv
// Self-checking bench for the LED7 level-current and light-comparator register slice.
`timescale 1ns/1ns
module tb;
  import led7_als_pkg::*;
  logic              clk               = 1'b0;
  logic              rst_b             = 1'b0;
  logic [7:0]        reg_addr          = 8'h00;
  logic              reg_wr            = 1'b0;
  logic [7:0]        reg_wdata         = 8'h00;
  logic [7:0]        reg_rd_data;
  logic              backlight_on      = 1'b0;
  logic              led7_range_select = 1'b0;
  logic [CMP_W-1:0]  cmp_main_in       = 4'h0;
  logic [CMP_W-1:0]  cmp_second_in     = 4'h0;
  logic [CODE_W-1:0] led7_drive_code;
  logic              led7_double_range;
  level_t            als_level;
  logic              chk               = 1'b0;
  logic              seen              = 1'b0;
  logic [9:0]        note;
  logic [9:0]        notes[$];
  logic [31:0]       rng               = 32'h0001269b;
  logic [6:0]        code4             = 7'h00;
  logic [6:0]        code5             = 7'h00;
  logic [3:0]        m;
  int                n_mismatch        = 0;
  int                n_compared        = 0;
  int                cycles            = 0;

  // A short filter period keeps the run brief; the conversion length stays as built.
  led7_als_regs #(.FILTER_CYCLES(20), .CONV_LEN(16)) u_led7_als_regs (
    .clk               (clk),
    .rst_b             (rst_b),
    .reg_addr          (reg_addr),
    .reg_wr            (reg_wr),
    .reg_wdata         (reg_wdata),
    .reg_rd_data       (reg_rd_data),
    .backlight_on      (backlight_on),
    .led7_range_select (led7_range_select),
    .cmp_main_in       (cmp_main_in),
    .cmp_second_in     (cmp_second_in),
    .led7_drive_code   (led7_drive_code),
    .led7_double_range (led7_double_range),
    .als_level         (als_level)
  );

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // Fixed-seed pseudo-random source.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // Reports one comparison; a mismatch is printed at once.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One bus cycle; every input is assigned once, so calls may run back to back.
  task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic c, input logic [9:0] n);
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= d;
    chk <= c;
    if (c)
      notes.push_back(n);
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, a, d, 1'b0, 10'h000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cyc(1'b0, a, 8'h00, 1'b1, {2'h0, e});
  endtask

  task automatic ex(input logic [1:0] s, input logic [7:0] e);
    cyc(1'b0, 8'h00, 8'h00, 1'b1, {s, e});
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 8'h00, 8'h00, 1'b0, 10'h000);
  endtask

  // Results land one edge after the check is launched, so they are taken at the falling edge.
  always @(posedge clk) seen <= chk;
  always @(negedge clk)
  begin
    if (seen)
    begin
      note = notes.pop_front();
      case (note[9:8])
        2'h0:    check(reg_rd_data, note[7:0]);
        2'h1:    check({1'b0, led7_drive_code}, note[7:0]);
        2'h2:    check({7'h00, led7_double_range}, note[7:0]);
        default: check({5'h00, als_level}, note[7:0]);
      endcase
    end
  end

  // A hang is cut short well beyond the few hundred cycles the sequence needs.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      results();
    end
  end

  // Main sequence.
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_LED7_L4, 8'h00);
    rd(ADDR_LED7_L5, 8'h00);
    rd(ADDR_LIGHT_CTRL, 8'h00);
    rd(ADDR_SMOOTH_MAIN, 8'h00);
    ex(2'h1, 8'h00);
    ex(2'h3, 8'h00);
    // Bit 7 is written high on purpose and must read back as zero.
    repeat (4)
    begin
      rng = xs(rng);
      code4 = rng[6:0];
      code5 = rng[14:8];
      wr(ADDR_LED7_L4, {1'b1, code4});
      rd(ADDR_LED7_L4, {1'b0, code4});
      wr(ADDR_LED7_L5, {1'b1, code5});
      rd(ADDR_LED7_L5, {1'b0, code5});
    end
    // Unmapped and read-only places ignore writes.
    wr(8'h2e, 8'hff);
    wr(ADDR_CMP_LAST, 8'hff);
    wr(8'h50, 8'hff);
    wr(ADDR_RAW_MAIN, 8'hff);
    rd(8'h2e, 8'h00);
    rd(ADDR_CMP_LAST, 8'h00);
    rd(8'h50, 8'h00);
    rd(ADDR_RAW_MAIN, 8'h00);
    // Every filter code in both fields; the loop ends with main code 0 for a short period.
    for (int f = 0; f < 8; f++)
    begin
      wr(ADDR_LIGHT_CTRL, {f[2:0], 1'b0, 3'(7 - f), 1'b0});
      rd(ADDR_LIGHT_CTRL, {f[2:0], 1'b0, 3'(7 - f), 1'b0});
    end
    led7_range_select <= 1'b1;
    idle(2);
    ex(2'h2, 8'h01);
    led7_range_select <= 1'b0;
    idle(2);
    ex(2'h2, 8'h00);
    // Forced reads with the backlight off self-clear after the conversion.
    cmp_main_in <= 4'h5;
    cmp_second_in <= 4'h9;
    idle(3);
    wr(ADDR_LIGHT_CTRL, 8'hf1);
    rd(ADDR_LIGHT_CTRL, 8'hf1);
    idle(20);
    rd(ADDR_LIGHT_CTRL, 8'he0);
    rd(ADDR_SMOOTH_MAIN, 8'h05);
    rd(ADDR_SMOOTH_SECOND, 8'h09);
    rd(ADDR_RAW_SECOND, 8'h09);
    // With the backlight on the force bits are not taken.
    backlight_on <= 1'b1;
    wr(ADDR_LIGHT_CTRL, 8'hf1);
    rd(ADDR_LIGHT_CTRL, 8'he0);
    backlight_on <= 1'b0;
    // Highest set comparator bit picks the level; levels 4 and 5 take their own code.
    for (int l = 1; l <= 5; l++)
    begin
      rng = xs(rng);
      m = (l == 1) ? 4'h0 : 4'(1 << (l - 2));
      cmp_main_in <= (l == 1) ? 4'h0 : (m | (rng[3:0] & (m - 4'h1)));
      idle(45);
      ex(2'h3, 8'(l - 1));
      ex(2'h1, (l == 4) ? {1'b0, code4} : (l == 5) ? {1'b0, code5} : 8'h00);
      rd(ADDR_RAW_MAIN, {4'h0, cmp_main_in});
    end
    idle(3);
    results();
  end
endmodule
